//--- rtl/eott_pkg.sv
// Package of constants, types and register map for the encoder and offset trigger timer.
package eott_pkg;
    // Register byte offsets on the APB bus.
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_START  = 8'h04;
    localparam logic [7:0] ADDR_CC0    = 8'h08;
    localparam logic [7:0] ADDR_CC1    = 8'h0C;
    localparam logic [7:0] ADDR_COUNT  = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    // Control register field positions.
    localparam int CTRL_RUN_BIT   = 0;
    localparam int CTRL_HOLD_BIT  = 1;
    localparam int CTRL_MODE_LSB  = 4;
    localparam int CTRL_DJ_LSB    = 8;
    localparam int CTRL_EDGE_LSB  = 10;
    localparam int CTRL_MCLR_LSB  = 12;
    localparam int CTRL_LDE_BIT   = 14;
    localparam int CTRL_CSRC_BIT  = 15;
    localparam int CTRL_CEDGE_LSB = 16;
    localparam int CTRL_IS0_LSB   = 18;
    localparam int CTRL_IS1_LSB   = 20;
    localparam int CTRL_OL0_BIT   = 22;
    // Mode codes.
    localparam logic [3:0] MODE_ENC_CMP  = 4'h8;
    localparam logic [3:0] MODE_ENC_CAP  = 4'h9;
    localparam logic [3:0] MODE_ENC_CC   = 4'hA;
    localparam logic [3:0] MODE_OFFSET   = 4'hC;
    // Two-bit select codes.
    localparam logic [1:0] SEL_00 = 2'h0;
    localparam logic [1:0] SEL_01 = 2'h1;
    localparam logic [1:0] SEL_10 = 2'h2;
    localparam logic [1:0] SEL_11 = 2'h3;
    // Reset values.
    localparam logic [15:0] COUNT_RESET = 16'hFFFF;
    localparam logic [15:0] COUNT_ZERO  = 16'h0000;
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
    // Operation clock becomes valid this many cycles after the run bit is set.
    localparam logic [1:0] START_SETTLE = 2'h2;
    // Control fields decoded from the control register.
    typedef struct packed {
        logic       run;
        logic       hold;
        logic [3:0] mode;
        logic [1:0] dj;
        logic [1:0] edge_sel;
        logic [1:0] mclr;
        logic       lde;
        logic       csrc;
        logic [1:0] cedge;
        logic [1:0] is0;
        logic [1:0] is1;
        logic       ol0;
    } eott_ctrl_t;
    // Event pulses of the counter.
    typedef struct packed {
        logic cc0;
        logic cc1;
        logic clr;
    } eott_evt_t;
endpackage : eott_pkg

//--- rtl/eott_timer.sv
// Encoder and offset trigger timer channel with APB register access.
`timescale 1ns/1ns
module eott_timer
    import eott_pkg::*;
(
    input  wire logic        CLK,          // System clock, 125 MHz.
    input  wire logic        RST_N,        // Asynchronous reset, active low.
    input  wire logic        PSEL,         // APB select.
    input  wire logic        PENABLE,      // APB enable.
    input  wire logic        PWRITE,       // APB direction.
    input  wire logic [7:0]  PADDR,        // APB byte address.
    input  wire logic [31:0] PWDATA,       // APB write data.
    output logic      [31:0] PRDATA,       // APB read data.
    output logic             PREADY,       // APB ready.
    output logic             PSLVERR,      // APB error for unmapped address.
    input  wire logic        PHASE_IN_A,   // Encoder phase A.
    input  wire logic        PHASE_IN_B,   // Encoder phase B.
    input  wire logic        ENCODER_CLEAR_IN, // Encoder clear input.
    input  wire logic        CAPTURE_IN_0, // Capture trigger 0.
    input  wire logic        CAPTURE_IN_1, // Capture trigger 1.
    output logic             MATCH_IRQ_0,  // Match or capture pulse 0.
    output logic             MATCH_IRQ_1,  // Match or capture pulse 1.
    output logic             TIMER_OUT_0,  // Timer output 0.
    output logic             TIMER_OUT_1   // Timer output 1.
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and helper functions.

    logic [1:0] rst_sync;
    logic       rst_n_i;

    // Two-stage release of the asynchronous reset.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n_i = rst_sync[1];

    // Edge match for a two-bit edge select: 01 rising, 10 falling, 11 both.
    function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
        edge_hit = (sel[0] && !prev && cur) || (sel[1] && prev && !cur);
    endfunction : edge_hit

    // Extracts the control fields from the raw control word.
    function automatic eott_ctrl_t unpack_ctrl(input logic [31:0] w);
        eott_ctrl_t c;
        c.run      = w[CTRL_RUN_BIT];
        c.hold     = w[CTRL_HOLD_BIT];
        c.mode     = w[CTRL_MODE_LSB +: 4];
        c.dj       = w[CTRL_DJ_LSB +: 2];
        c.edge_sel = w[CTRL_EDGE_LSB +: 2];
        c.mclr     = w[CTRL_MCLR_LSB +: 2];
        c.lde      = w[CTRL_LDE_BIT];
        c.csrc     = w[CTRL_CSRC_BIT];
        c.cedge    = w[CTRL_CEDGE_LSB +: 2];
        c.is0      = w[CTRL_IS0_LSB +: 2];
        c.is1      = w[CTRL_IS1_LSB +: 2];
        c.ol0      = w[CTRL_OL0_BIT];
        unpack_ctrl = c;
    endfunction : unpack_ctrl

    ////////////////////////////////////////////////////////////////////////////
    // Register bus.

    logic [31:0] ctrl_reg, next_ctrl_reg;
    logic [15:0] start_reg, next_start_reg;
    logic [15:0] cc0_reg, next_cc0_reg;
    logic [15:0] cc1_reg, next_cc1_reg;
    logic [31:0] next_prdata;
    logic        next_pready, next_pslverr;
    logic        wr_en, rd_en, addr_ok;
    logic [15:0] count;
    logic [2:0]  status;
    logic        cap0_now, cap1_now;
    logic        run_q, out0, out1;
    logic [15:0] cc1_buf;
    eott_ctrl_t  c;

    assign c       = unpack_ctrl(ctrl_reg);
    assign addr_ok = (PADDR == ADDR_CTRL) || (PADDR == ADDR_START) || (PADDR == ADDR_CC0)
                  || (PADDR == ADDR_CC1) || (PADDR == ADDR_COUNT) || (PADDR == ADDR_STATUS);
    assign wr_en   = PSEL && PENABLE && !PREADY && PWRITE && addr_ok;
    assign rd_en   = PSEL && PENABLE && !PREADY && !PWRITE;

    // Register writes, read mux and one-wait-state answer; captures overwrite the capture registers.
    always_comb begin
        next_ctrl_reg  = ctrl_reg;
        next_start_reg = start_reg;
        next_cc0_reg   = cc0_reg;
        next_cc1_reg   = cc1_reg;
        next_pready    = PSEL && PENABLE && !PREADY;
        next_pslverr   = PSEL && PENABLE && !PREADY && !addr_ok;
        next_prdata    = PRDATA;
        if (wr_en) begin
            case (PADDR)
                ADDR_CTRL:  next_ctrl_reg  = PWDATA;
                ADDR_START: next_start_reg = PWDATA[15:0];
                ADDR_CC0:   next_cc0_reg   = PWDATA[15:0];
                ADDR_CC1:   next_cc1_reg   = PWDATA[15:0];
                default:    next_ctrl_reg  = ctrl_reg;
            endcase
        end
        if (cap0_now) begin
            next_cc0_reg = count;
        end
        if (cap1_now) begin
            next_cc1_reg = count;
        end
        if (rd_en) begin
            case (PADDR)
                ADDR_CTRL:   next_prdata = ctrl_reg;
                ADDR_START:  next_prdata = {16'h0000, start_reg};
                ADDR_CC0:    next_prdata = {16'h0000, cc0_reg};
                ADDR_CC1:    next_prdata = {16'h0000, cc1_reg};
                ADDR_COUNT:  next_prdata = {16'h0000, count};
                ADDR_STATUS: next_prdata = {27'h0000000, status, run_q, c.run};
                default:     next_prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_reg  <= CTRL_RESET;
            start_reg <= COUNT_ZERO;
            cc0_reg   <= COUNT_ZERO;
            cc1_reg   <= COUNT_ZERO;
            PRDATA    <= 32'h0000_0000;
            PREADY    <= 1'b0;
            PSLVERR   <= 1'b0;
        end else begin
            ctrl_reg  <= next_ctrl_reg;
            start_reg <= next_start_reg;
            cc0_reg   <= next_cc0_reg;
            cc1_reg   <= next_cc1_reg;
            PRDATA    <= next_prdata;
            PREADY    <= next_pready;
            PSLVERR   <= next_pslverr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter core.

    logic        pa_q, pb_q, clr_q, ci0_q, ci1_q;
    logic        hold_act, next_hold_act;
    logic [1:0]  settle, next_settle;
    logic        load_pend, next_load_pend;
    logic [15:0] next_count, next_cc1_buf;
    logic        next_out0, next_out1, next_run_q;
    logic        up_step, dn_step, is_enc, is_cap;
    logic        m0, m1, clr_edge, cap0_edge, cap1_edge;
    eott_evt_t   evt;
    logic [2:0]  next_status;

    assign is_enc    = (c.mode == MODE_ENC_CMP) || (c.mode == MODE_ENC_CAP) || (c.mode == MODE_ENC_CC);
    assign is_cap    = (c.mode == MODE_ENC_CAP);
    assign cap0_edge = edge_hit(c.is0, ci0_q, CAPTURE_IN_0);
    assign cap1_edge = edge_hit(c.is1, ci1_q, CAPTURE_IN_1);
    assign cap0_now  = run_q && ((is_cap || c.mode == MODE_OFFSET) && cap0_edge);
    assign cap1_now  = run_q && (is_cap || c.mode == MODE_ENC_CC) && cap1_edge;
    assign clr_edge  = run_q && is_enc && !c.csrc && edge_hit(c.cedge, clr_q, ENCODER_CLEAR_IN);

    // Direction detection from the encoder phases.
    always_comb begin
        up_step = 1'b0;
        dn_step = 1'b0;
        case (c.dj)
            SEL_00: begin
                if (edge_hit(c.edge_sel, pa_q, PHASE_IN_A)) begin
                    up_step = !PHASE_IN_B;
                    dn_step = PHASE_IN_B;
                end
            end
            SEL_11: begin
                // Quadrature x4 decode: any legal phase step counts.
                if ((pa_q != PHASE_IN_A) ^ (pb_q != PHASE_IN_B)) begin
                    up_step = (pa_q ^ PHASE_IN_B);
                    dn_step = !(pa_q ^ PHASE_IN_B);
                end
            end
            default: begin
                up_step = 1'b0;
                dn_step = 1'b0;
            end
        endcase
    end

    assign m0 = is_enc && !is_cap && (count == cc0_reg);
    assign m1 = (c.mode == MODE_ENC_CMP || c.mode == MODE_OFFSET) && (count == cc1_buf);

    // Counter, start logic, compare and outputs.
    always_comb begin
        next_count     = count;
        next_hold_act  = hold_act;
        next_settle    = settle;
        next_load_pend = load_pend;
        next_cc1_buf   = (c.mode == MODE_OFFSET) ? cc1_buf : cc1_reg;
        next_run_q     = c.run;
        next_out0      = out0;
        next_out1      = out1;
        evt            = '0;
        next_status    = status;
        if (!c.run) begin
            next_hold_act = c.hold;
            next_settle   = 2'h0;
            if (hold_act && !c.hold) begin
                next_count = COUNT_RESET;
            end
        end else if (!run_q) begin
            next_load_pend = !hold_act;
            next_settle    = 2'h1;
        end else if (settle != START_SETTLE) begin
            next_settle = settle + 2'h1;
            if (c.hold != hold_act) begin
                next_load_pend = 1'b0;
            end
        end else if (load_pend) begin
            next_count     = start_reg;
            next_load_pend = 1'b0;
        end else if (is_enc) begin
            if (up_step) begin
                next_count = count + 16'h0001;
                if (m0 && c.mclr[0]) begin
                    next_count = COUNT_ZERO;
                end
            end else if (dn_step) begin
                next_count = count - 16'h0001;
                if (m1 && c.mclr == SEL_11) begin
                    next_count = COUNT_ZERO;
                end else if (count == COUNT_ZERO && c.lde && c.mclr != SEL_11) begin
                    next_count = cc0_reg;
                end
            end
            if (clr_edge) begin
                next_count = COUNT_ZERO;
            end
            evt.cc0 = (m0 && (up_step || dn_step)) || cap0_now;
            evt.cc1 = (m1 && (up_step || dn_step)) || cap1_now;
        end else if (c.mode == MODE_OFFSET) begin
            next_count = count + 16'h0001;
            evt.cc1    = m1;
            if (m1) begin
                next_out1 = 1'b0;
            end
            if (cap0_now) begin
                next_count   = COUNT_ZERO;
                next_cc1_buf = cc1_reg;
                next_out1    = 1'b1;
                evt.cc0      = 1'b1;
            end
        end
        next_out0 = (c.mode == MODE_OFFSET) ? c.ol0 : 1'b0;
        evt.clr   = clr_edge;
        if (evt != '0) begin
            next_status = evt; // The latest events are kept until others arrive.
        end
    end

    always_ff @(posedge CLK or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pa_q        <= 1'b0;
            pb_q        <= 1'b0;
            clr_q       <= 1'b0;
            ci0_q       <= 1'b0;
            ci1_q       <= 1'b0;
            hold_act    <= 1'b0;
            settle      <= 2'h0;
            load_pend   <= 1'b0;
            count       <= COUNT_RESET;
            cc1_buf     <= COUNT_ZERO;
            run_q       <= 1'b0;
            out0        <= 1'b0;
            out1        <= 1'b0;
            status      <= 3'h0;
            MATCH_IRQ_0 <= 1'b0;
            MATCH_IRQ_1 <= 1'b0;
            TIMER_OUT_0 <= 1'b0;
            TIMER_OUT_1 <= 1'b0;
        end else begin
            pa_q        <= PHASE_IN_A;
            pb_q        <= PHASE_IN_B;
            clr_q       <= ENCODER_CLEAR_IN;
            ci0_q       <= CAPTURE_IN_0;
            ci1_q       <= CAPTURE_IN_1;
            hold_act    <= next_hold_act;
            settle      <= next_settle;
            load_pend   <= next_load_pend;
            count       <= next_count;
            cc1_buf     <= next_cc1_buf;
            run_q       <= next_run_q;
            out0        <= next_out0;
            out1        <= next_out1;
            status      <= next_status;
            MATCH_IRQ_0 <= evt.cc0;
            MATCH_IRQ_1 <= evt.cc1;
            TIMER_OUT_0 <= next_out0;
            TIMER_OUT_1 <= next_out1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    property p_hold_stop;
        @(posedge CLK) disable iff (!rst_n_i)
        (!c.run && hold_act && !c.hold) |=> (count == COUNT_RESET);
    endproperty
    a_hold_stop: assert property (p_hold_stop) else $error("Counter not reset on hold fall.");

    property p_run_frozen;
        @(posedge CLK) disable iff (!rst_n_i)
        (c.run && run_q) |=> $stable(hold_act);
    endproperty
    a_run_frozen: assert property (p_run_frozen) else $error("Hold changed while running.");

    property p_load;
        @(posedge CLK) disable iff (!rst_n_i)
        ($rose(run_q) && c.run && load_pend && c.hold == hold_act) ##1 c.run
            |=> (count == $past(start_reg));
    endproperty
    a_load: assert property (p_load) else $error("Start value not loaded.");

    property p_off_clear;
        @(posedge CLK) disable iff (!rst_n_i)
        (c.run && run_q && settle == START_SETTLE && !load_pend && c.mode == MODE_OFFSET && cap0_now)
            |=> (count == COUNT_ZERO && TIMER_OUT_1 && MATCH_IRQ_0);
    endproperty
    a_off_clear: assert property (p_off_clear) else $error("Offset capture did not clear.");

    property p_out0;
        @(posedge CLK) disable iff (!rst_n_i)
        (c.mode == MODE_OFFSET) |=> (TIMER_OUT_0 == $past(c.ol0));
    endproperty
    a_out0: assert property (p_out0) else $error("Output 0 level wrong.");

    property p_buf;
        @(posedge CLK) disable iff (!rst_n_i)
        (c.mode == MODE_OFFSET && !cap0_now && $past(c.mode) == MODE_OFFSET) |=> $stable(cc1_buf);
    endproperty
    a_buf: assert property (p_buf) else $error("Compare buffer reloaded early.");

    property p_clr_edge;
        @(posedge CLK) disable iff (!rst_n_i)
        (c.run && clr_edge && settle == START_SETTLE && !load_pend) |=> (count == COUNT_ZERO);
    endproperty
    a_clr_edge: assert property (p_clr_edge) else $error("Clear input ignored.");

    property p_nomclr;
        @(posedge CLK) disable iff (!rst_n_i)
        (c.run && run_q && settle == START_SETTLE && !load_pend && is_enc && c.mclr == SEL_00
            && !clr_edge && up_step)
            |=> (count == $past(count) + 16'h0001);
    endproperty
    a_nomclr: assert property (p_nomclr) else $error("Counter cleared without select.");

endmodule : eott_timer

//--- verification/eott_encoder_model.sv
// Far-side model: quadrature encoder, clear input and capture trigger sources.
`timescale 1ns/1ns
module eott_encoder_model (
    input  wire logic CLK,              // System clock.
    output logic      PHASE_IN_A,       // Phase A.
    output logic      PHASE_IN_B,       // Phase B.
    output logic      ENCODER_CLEAR_IN, // Clear input.
    output logic      CAPTURE_IN_0,     // Capture trigger 0.
    output logic      CAPTURE_IN_1      // Capture trigger 1.
);
    logic [1:0] ph;
    // All lines start low with the quadrature position at zero.
    initial begin
        ph = 2'h0;
        {PHASE_IN_A, PHASE_IN_B, ENCODER_CLEAR_IN, CAPTURE_IN_0, CAPTURE_IN_1} = 5'h00;
    end
    // Every level is held long enough for the edge detector to see it.
    task automatic settle();
        repeat (4) @(posedge CLK);
    endtask : settle
    // One quadrature step; phase A leads B when stepping up.
    task automatic quad(input logic up);
        ph = up ? ph + 2'h1 : ph - 2'h1;
        @(posedge CLK);
        PHASE_IN_A <= ph[0] ^ ph[1];
        PHASE_IN_B <= ph[1];
        settle();
    endtask : quad
    // Direction level on B first, then one rising edge on A.
    task automatic pulse_a(input logic b);
        @(posedge CLK);
        PHASE_IN_B <= b;
        settle();
        PHASE_IN_A <= 1'b1;
        settle();
        PHASE_IN_A <= 1'b0;
        settle();
    endtask : pulse_a
    // Rising edge then fall on the clear input (0) or a capture input (1 or 2).
    task automatic pulse(input int which);
        @(posedge CLK);
        ENCODER_CLEAR_IN <= (which == 0);
        CAPTURE_IN_0     <= (which == 1);
        CAPTURE_IN_1     <= (which == 2);
        settle();
        {ENCODER_CLEAR_IN, CAPTURE_IN_0, CAPTURE_IN_1} <= 3'h0;
        settle();
    endtask : pulse
endmodule : eott_encoder_model

//--- verification/eott_timer_tb.sv
// Self-checking bench for the encoder and offset trigger timer.
`timescale 1ns/1ns
module eott_timer_tb
    import eott_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdata, cm;
    logic        pready, pslverr, rerr, pa, pb, eclr, cp0, cp1, irq0, irq1, out0, out1, bup;
    logic [15:0] s, d;
    int          error_cnt = 0, samples_checked = 0, cyc = 0, n0 = 0, n1 = 0, t0 = 0, t1 = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock of 8 ns period.
    always #4 clk = ~clk;
    eott_timer DUT (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .PHASE_IN_A(pa), .PHASE_IN_B(pb), .ENCODER_CLEAR_IN(eclr), .CAPTURE_IN_0(cp0),
        .CAPTURE_IN_1(cp1), .MATCH_IRQ_0(irq0), .MATCH_IRQ_1(irq1), .TIMER_OUT_0(out0),
        .TIMER_OUT_1(out1));
    eott_encoder_model ENC (.CLK(clk), .PHASE_IN_A(pa), .PHASE_IN_B(pb), .ENCODER_CLEAR_IN(eclr),
        .CAPTURE_IN_0(cp0), .CAPTURE_IN_1(cp1));
    // Event pulse counts and times, plus the hang limit.
    always @(posedge clk) begin
        cyc++;
        if (irq0 === 1'b1) begin
            n0++;
            t0 = cyc;
        end
        if (irq1 === 1'b1) begin
            n1++;
            t1 = cyc;
        end
        if (cyc == 20000) begin
            error_cnt++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Compares one value and counts the outcome.
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One APB transfer; waits on PREADY under a bound.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= dat;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 40);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 40) chk("pready", 32'h1, 32'h0);
    endtask : apb
    // Reads the counter and compares its low half.
    task automatic rdc(input logic [15:0] e, input string nm);
        apb(1'b0, ADDR_COUNT, 32'h0);
        chk(nm, {16'h0, e}, {16'h0, rdata[15:0]});
    endtask : rdc
    // Control word with rising edges chosen for every input.
    function automatic logic [31:0] ctl(logic [3:0] md, logic [1:0] dj, logic [1:0] mc, logic lde, logic ol);
        logic [31:0] c;
        c = CTRL_RESET;
        c[CTRL_MODE_LSB+:4] = md;
        c[CTRL_DJ_LSB+:2] = dj;
        c[CTRL_EDGE_LSB+:2] = SEL_01;
        c[CTRL_MCLR_LSB+:2] = mc;
        c[CTRL_LDE_BIT] = lde;
        c[CTRL_CEDGE_LSB+:2] = SEL_01;
        c[CTRL_IS0_LSB+:2] = SEL_01;
        c[CTRL_IS1_LSB+:2] = SEL_01;
        c[CTRL_OL0_BIT] = ol;
        return c;
    endfunction : ctl
    // Stops, loads start and compare values, then starts with hold clear.
    task automatic go(input logic [31:0] c, input logic [15:0] st, input logic [15:0] c0, input logic [15:0] c1);
        apb(1'b1, ADDR_CTRL, c);
        apb(1'b1, ADDR_START, {16'h0, st});
        apb(1'b1, ADDR_CC0, {16'h0, c0});
        apb(1'b1, ADDR_CC1, {16'h0, c1});
        apb(1'b1, ADDR_CTRL, c | 32'h1);
        repeat (6) @(posedge clk);
        n0 = 0;
        n1 = 0;
    endtask : go
    // Phase A edges counting up or down.
    task automatic mv(input int k, input logic up);
        repeat (k) ENC.pulse_a(up ? bup : ~bup);
    endtask : mv
    // Prints the counts and the verdict, then ends the run.
    task automatic complete_run();
        $display("Checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        void'($urandom(56630));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rdc(COUNT_RESET, "count rst");
        apb(1'b0, 8'h40, 32'h0);
        chk("slverr", 32'h1, {31'h0, rerr});
        chk("unmapped", 32'h0, rdata);
        cm = ctl(MODE_ENC_CMP, SEL_00, SEL_00, 1'b0, 1'b0);
        s = 16'(16'h1000 + $urandom % 16'h4000);
        go(cm, s, 16'h7000, 16'h7000);
        rdc(s, "start load");
        apb(1'b1, ADDR_CTRL, cm | 32'h3);
        apb(1'b1, ADDR_CTRL, cm | 32'h1);
        rdc(s, "run hold");
        apb(1'b1, ADDR_CTRL, cm | 32'h3);
        apb(1'b1, ADDR_CTRL, cm | 32'h2);
        rdc(s, "stop hold");
        apb(1'b1, ADDR_CTRL, cm);
        rdc(COUNT_RESET, "hold fall");
        apb(1'b1, ADDR_CTRL, cm | 32'h2);
        apb(1'b1, ADDR_CTRL, cm | 32'h3);
        repeat (6) @(posedge clk);
        rdc(COUNT_RESET, "no load");
        go(ctl(MODE_ENC_CMP, SEL_11, SEL_00, 1'b0, 1'b0), 16'h0100, 16'h7000, 16'h7000);
        repeat (4) ENC.quad(1'b1);
        apb(1'b0, ADDR_COUNT, 32'h0);
        d = rdata[15:0] - 16'h0100;
        chk("quad step", 32'h1, {31'h0, d == 16'h0004 || d == 16'hFFFC});
        repeat (4) ENC.quad(1'b0);
        rdc(16'h0100, "quad back");
        go(cm, 16'h0100, 16'h7000, 16'h7000);
        repeat (3) ENC.pulse_a(1'b0);
        apb(1'b0, ADDR_COUNT, 32'h0);
        d = rdata[15:0] - 16'h0100;
        chk("a edge step", 32'h1, {31'h0, d == 16'h0003 || d == 16'hFFFD});
        bup = (d == 16'h0003) ? 1'b0 : 1'b1;
        mv(3, 1'b0);
        rdc(16'h0100, "a edge back");
        go(cm, s, s + 16'h2, 16'h7000);
        mv(3, 1'b1);
        rdc(s + 16'h3, "no clear");
        chk("irq0 count", 32'h1, n0);
        go(ctl(MODE_ENC_CMP, SEL_00, SEL_01, 1'b0, 1'b0), s, s + 16'h2, 16'h7000);
        mv(3, 1'b1);
        rdc(COUNT_ZERO, "up clear");
        go(ctl(MODE_ENC_CMP, SEL_00, SEL_01, 1'b1, 1'b0), 16'h0001, 16'h0050, 16'h7000);
        mv(2, 1'b0);
        rdc(16'h0050, "reload");
        go(ctl(MODE_ENC_CMP, SEL_00, SEL_11, 1'b1, 1'b0), 16'h0001, 16'h7000, 16'h7000);
        mv(2, 1'b0);
        rdc(COUNT_RESET, "reload off");
        go(ctl(MODE_ENC_CMP, SEL_00, SEL_11, 1'b0, 1'b0), 16'h0006, 16'h7000, 16'h0005);
        mv(2, 1'b0);
        rdc(COUNT_ZERO, "down clear");
        chk("irq1 count", 32'h1, n1);
        go(cm, s, 16'h7000, 16'h7000);
        ENC.pulse(0);
        rdc(COUNT_ZERO, "ext clear");
        go(ctl(MODE_ENC_CAP, SEL_00, SEL_00, 1'b0, 1'b0), s, 16'h0000, 16'h0000);
        ENC.pulse(1);
        ENC.pulse(2);
        apb(1'b0, ADDR_CC0, 32'h0);
        chk("cap0", {16'h0, s}, rdata);
        apb(1'b0, ADDR_CC1, 32'h0);
        chk("cap1", {16'h0, s}, rdata);
        chk("cap irqs", 32'h2, n0 + n1);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("status", 32'h0000_000B, rdata);
        go(ctl(MODE_ENC_CC, SEL_00, SEL_00, 1'b0, 1'b0), s, 16'h7000, 16'h0000);
        ENC.pulse(2);
        apb(1'b0, ADDR_CC1, 32'h0);
        chk("cc cap1", {16'h0, s}, rdata);
        apb(1'b0, ADDR_CC0, 32'h0);
        chk("cc cmp0", 32'h7000, rdata);
        go(ctl(MODE_OFFSET, SEL_00, SEL_00, 1'b0, 1'b1), 16'h0000, 16'h0000, 16'h0040);
        chk("out0 high", 32'h1, {31'h0, out0});
        ENC.pulse(1);
        chk("out1 set", 32'h1, {31'h0, out1});
        chk("ofs irq0", 32'h1, n0);
        apb(1'b1, ADDR_CC1, 32'h0080);
        repeat (16'h60) @(posedge clk);
        chk("gap old", 32'h1, {31'h0, t1 - t0 >= 16'h3F && t1 - t0 <= 16'h42});
        chk("out1 reset", 32'h0, {31'h0, out1});
        ENC.pulse(1);
        apb(1'b0, ADDR_COUNT, 32'h0);
        chk("ofs clear", 32'h1, {31'h0, rdata[15:0] < 16'h0020});
        repeat (16'hA0) @(posedge clk);
        chk("gap new", 32'h1, {31'h0, t1 - t0 >= 16'h7F && t1 - t0 <= 16'h82});
        apb(1'b1, ADDR_CTRL, ctl(MODE_OFFSET, SEL_00, SEL_00, 1'b0, 1'b0) | 32'h1);
        repeat (3) @(posedge clk);
        chk("out0 low", 32'h0, {31'h0, out0});
        complete_run();
    end
endmodule : eott_timer_tb
